// [mmi_bp_match.sv]
// breakpoint address comparators for operand and program refs
`timescale 1ns/1ps
`default_nettype none
module mmi_bp_match #(
  parameter int AW = 48
) (
  // breakpoint contents and mode
  input  wire logic [AW-1:0] bp_addr,
  input  wire logic [6:0]    usage,
  input  wire logic          monitor,
  // operand reference from the pipeline
  input  wire logic          ref_valid,
  input  wire logic [2:0]    ref_slot,
  input  wire logic [AW-1:0] ref_vaddr,
  input  wire logic [AW-1:0] ref_aaddr,
  input  wire logic          ref_excl,
  // completed instruction address
  input  wire logic          pc_valid,
  input  wire logic [AW-1:0] pc_vaddr,
  input  wire logic [AW-1:0] pc_aaddr,
  // match results
  output logic               ref_hit,
  output logic               pc_hit
);
  logic [AW-1:0] ref_addr; // address space chosen by mode
  logic [AW-1:0] pc_addr;

  // ==========================================================
  // job mode sees virtual, monitor mode absolute addresses
  assign ref_addr = monitor ? ref_aaddr : ref_vaddr;
  assign pc_addr  = monitor ? pc_aaddr : pc_vaddr;

  // ==========================================================
  // operands match per sword; slot 6 is never an operand
  assign ref_hit = ref_valid && !ref_excl && (ref_slot < 3'h6) &&
                   usage[ref_slot] &&
                   (ref_addr[AW-1:mmi_pkg::SWORD_LSB] ==
                    bp_addr[AW-1:mmi_pkg::SWORD_LSB]);

  // program address matches per half-word
  assign pc_hit = pc_valid && usage[6] &&
                  (pc_addr[AW-1:mmi_pkg::HALF_LSB] ==
                   bp_addr[AW-1:mmi_pkg::HALF_LSB]);
endmodule // mmi_bp_match
`default_nettype wire

// [mmi_instr_unit.sv]
// maintenance and monitor instruction execution unit
`timescale 1ns/1ps
`default_nettype none
module mmi_instr_unit #(
  parameter int AW = 48,
  parameter int DW = 64
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // instruction issue
  input  wire logic          instr_valid,
  input  wire logic [7:0]    instr_op,
  input  wire logic [7:0]    instr_r,
  input  wire logic [7:0]    instr_t,
  input  wire logic [AW-1:0] instr_paddr,
  input  wire logic          monitor_mode,
  output logic               instr_ready_q,
  output logic               instr_done_q,
  // designated register contents
  input  wire logic [DW-1:0] reg_r_val,
  input  wire logic [DW-1:0] reg_s_val,
  input  wire logic [DW-1:0] reg_t_val,
  // register file write
  output logic               rf_we_q,
  output logic [7:0]         rf_waddr_q,
  output logic [DW-1:0]      rf_wdata_q,
  // memory read for the field scan
  output logic               mem_req_q,
  output logic [AW-1:0]      mem_addr_q,
  input  wire logic          mem_ack,
  input  wire logic [DW-1:0] mem_rdata,
  // references and completions from the pipeline
  input  wire logic          ref_valid,
  input  wire logic [2:0]    ref_slot,
  input  wire logic [AW-1:0] ref_vaddr,
  input  wire logic [AW-1:0] ref_aaddr,
  input  wire logic          ref_scalar,
  input  wire logic          ref_table,
  input  wire logic          ref_io,
  input  wire logic          exec_done,
  input  wire logic [AW-1:0] exec_vaddr,
  input  wire logic [AW-1:0] exec_aaddr,
  // breakpoint and exchange
  input  wire logic          exchange_to_monitor,
  output logic               bp_flag_q,
  // stack void and branch
  output logic               stack_void_q,
  output logic               branch_q,
  output logic [AW-1:0]      branch_addr_q,
  // memory fault test modes
  output logic               ecc_bypass_q,
  output logic [6:0]         checkword_inv_q,
  // privilege trap
  output logic               trap_q,
  output logic [7:0]         trap_fcode_q,
  output logic [AW-1:0]      trap_paddr_q,
  output logic [7:0]         trap_entry_reg_q,
  // idle and external interrupt pin
  input  wire logic          ext_irq,
  output logic               ext_int_en_q,
  output logic               idle_q,
  // i/o channel flags, bit 0 is channel 1
  output logic [11:0]        chan_flag_q
);
  // ==========================================================
  // declarations
  mmi_pkg::mmi_state_e state_q;    // sequencer
  logic [DW-1:0]       bp_q;       // breakpoint_match_register
  logic                bp_pend_q;  // operand hit awaiting completion
  logic [AW-1:0]       pc_addr_q;  // next bit to scan
  logic [15:0]         pc_left_q;  // bits still to scan
  logic [15:0]         pc_cnt_q;   // ones found so far
  logic [7:0]          pc_dst_q;   // destination register number
  logic [2:0]          irq_sync_q; // pin synchroniser
  logic                irq_on;     // debounced interrupt level
  logic                accept;     // instruction taken this cycle
  logic                priv_op;    // monitor-only opcode
  logic [6:0]          room;       // bits left in current word
  logic [6:0]          span;       // bits counted this word
  logic [6:0]          ones;       // ones in this word
  logic                last_word;  // field ends in this word
  logic [AW-1:0]       pop_start;  // base plus index
  logic [15:0]         pop_len;    // field length in bits
  logic                ref_hit;    // operand address matched
  logic                pc_hit;     // program address matched
  logic                ref_excl;   // references never compared

  assign accept  = instr_valid && instr_ready_q;
  assign priv_op = (instr_op == mmi_pkg::OP_IDLE) ||
                   (instr_op == mmi_pkg::OP_CHAN);

  // ==========================================================
  // field scan arithmetic
  assign pop_len   = reg_r_val[DW-1:mmi_pkg::LEN_LSB];
  assign pop_start = reg_r_val[AW-1:0] + reg_s_val[AW-1:0];
  assign room      = 7'h40 - {1'b0, pc_addr_q[5:0]};
  assign span      = ({9'h000, room} < pc_left_q) ? room
                                                  : pc_left_q[6:0];
  assign last_word = ({9'h000, span} == pc_left_q);

  // one word of the field per memory answer
  mmi_ones_count #(
    .W (DW)
  ) u_ones (
    .word  (mem_rdata),
    .first (pc_addr_q[5:0]),
    .n     (span),
    .ones  (ones)
  );

  // ==========================================================
  // breakpoint comparison; scalar, table, channel refs excluded
  assign ref_excl = ref_scalar || ref_table || ref_io;

  mmi_bp_match #(
    .AW (AW)
  ) u_bp (
    .bp_addr   (bp_q[AW-1:0]),
    .usage     (bp_q[mmi_pkg::BP_USE_HI:mmi_pkg::BP_USE_LO]),
    .monitor   (monitor_mode),
    .ref_valid (ref_valid),
    .ref_slot  (ref_slot),
    .ref_vaddr (ref_vaddr),
    .ref_aaddr (ref_aaddr),
    .ref_excl  (ref_excl),
    .pc_valid  (exec_done),
    .pc_vaddr  (exec_vaddr),
    .pc_aaddr  (exec_aaddr),
    .ref_hit   (ref_hit),
    .pc_hit    (pc_hit)
  );

  // ==========================================================
  // interrupt pin: three stages, level high only while the last two are both high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_sync_q <= 3'h0;
    end else begin
      irq_sync_q <= {irq_sync_q[1:0], ext_irq};
    end
  end
  assign irq_on = irq_sync_q[1] && irq_sync_q[2];

  // ==========================================================
  // sequencer and instruction handshake
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q       <= mmi_pkg::ST_READY;
      instr_ready_q <= 1'b0;
      instr_done_q  <= 1'b0;
    end else begin
      instr_done_q <= 1'b0;
      case (state_q)
        mmi_pkg::ST_READY: begin
          instr_ready_q <= 1'b1;
          if (accept) begin
            if (instr_op == mmi_pkg::OP_POPCNT && pop_len != 16'h0) begin
              state_q       <= mmi_pkg::ST_FETCH;
              instr_ready_q <= 1'b0;
            end else if (instr_op == mmi_pkg::OP_IDLE && monitor_mode) begin
              state_q       <= mmi_pkg::ST_HALT;
              instr_ready_q <= 1'b0;
            end else if (!(priv_op && !monitor_mode)) begin
              instr_done_q <= 1'b1;
            end
          end
        end
        mmi_pkg::ST_FETCH: begin
          // scan ends when all bits are counted
          if (mem_ack && last_word) begin
            state_q       <= mmi_pkg::ST_READY;
            instr_ready_q <= 1'b1;
            instr_done_q  <= 1'b1;
          end
        end
        mmi_pkg::ST_HALT: begin
          // execution suspended until an interrupt arrives
          if (irq_on) begin
            state_q       <= mmi_pkg::ST_READY;
            instr_ready_q <= 1'b1;
            instr_done_q  <= 1'b1;
          end
        end
        default: begin
          state_q       <= mmi_pkg::ST_READY;
          instr_ready_q <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // field scan datapath and register write of the count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_addr_q  <= '0;
      pc_left_q  <= 16'h0;
      pc_cnt_q   <= 16'h0;
      pc_dst_q   <= 8'h00;
      mem_req_q  <= 1'b0;
      mem_addr_q <= '0;
      rf_we_q    <= 1'b0;
      rf_waddr_q <= 8'h00;
      rf_wdata_q <= '0;
    end else begin
      rf_we_q <= 1'b0;
      if (accept && instr_op == mmi_pkg::OP_POPCNT) begin
        pc_addr_q <= pop_start;
        pc_left_q <= pop_len;
        pc_cnt_q  <= 16'h0;
        pc_dst_q  <= instr_t;
        if (pop_len == 16'h0) begin
          // empty field still clears the destination
          rf_we_q    <= 1'b1;
          rf_waddr_q <= instr_t;
          rf_wdata_q <= '0;
        end else begin
          mem_req_q  <= 1'b1;
          mem_addr_q <= {pop_start[AW-1:mmi_pkg::WORD_LSB], 6'h00};
        end
      end else if (state_q == mmi_pkg::ST_FETCH && mem_ack) begin
        // left to right, one word per answer
        pc_addr_q <= pc_addr_q + {{(AW-7){1'b0}}, span};
        pc_left_q <= pc_left_q - {9'h000, span};
        pc_cnt_q  <= pc_cnt_q + {9'h000, ones};
        mem_addr_q <= {pc_addr_q[AW-1:mmi_pkg::WORD_LSB] + 42'h1, 6'h00};
        if (last_word) begin
          mem_req_q  <= 1'b0;
          rf_we_q    <= 1'b1;
          rf_waddr_q <= pc_dst_q;
          rf_wdata_q <= {48'h0, pc_cnt_q + {9'h000, ones}};
        end
      end
    end
  end

  // ==========================================================
  // breakpoint register; exchange clear beats a same-cycle load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bp_q <= mmi_pkg::BP_RESET;
    end else if (exchange_to_monitor) begin
      bp_q <= mmi_pkg::BP_RESET;
    end else if (accept && instr_op == mmi_pkg::OP_BRKPT) begin
      bp_q <= reg_r_val;
    end
  end

  // ==========================================================
  // hits wait for completion; a hit in the completing cycle counts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bp_pend_q <= 1'b0;
      bp_flag_q <= 1'b0;
    end else begin
      bp_flag_q <= exec_done && (bp_pend_q || ref_hit || pc_hit);
      if (exec_done) begin
        bp_pend_q <= 1'b0;
      end else if (ref_hit) begin
        bp_pend_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // void stack and branch, one-cycle pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_void_q  <= 1'b0;
      branch_q      <= 1'b0;
      branch_addr_q <= '0;
    end else begin
      stack_void_q <= 1'b0;
      branch_q     <= 1'b0;
      if (accept && instr_op == mmi_pkg::OP_VOID) begin
        stack_void_q  <= 1'b1;
        branch_q      <= 1'b1;
        branch_addr_q <= reg_t_val[AW-1:0];
      end
    end
  end

  // ==========================================================
  // fault test modes; software must zero them before job entry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ecc_bypass_q    <= 1'b0;
      checkword_inv_q <= mmi_pkg::INV_RESET;
    end else if (accept && instr_op == mmi_pkg::OP_FAULT &&
                 monitor_mode) begin
      ecc_bypass_q    <= instr_r[mmi_pkg::FT_BYPASS];
      checkword_inv_q <= instr_r[6:0];
    end
  end

  // ==========================================================
  // privilege trap, taken like an undefined opcode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trap_q           <= 1'b0;
      trap_fcode_q     <= 8'h00;
      trap_paddr_q     <= '0;
      trap_entry_reg_q <= 8'h00;
    end else begin
      trap_q <= 1'b0;
      if (accept && priv_op && !monitor_mode) begin
        trap_q           <= 1'b1;
        trap_fcode_q     <= instr_op;
        trap_paddr_q     <= instr_paddr;
        trap_entry_reg_q <= mmi_pkg::TRAP_REG;
      end
    end
  end

  // ==========================================================
  // idle: interrupt enable held for the whole wait
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_q       <= 1'b0;
      ext_int_en_q <= 1'b0;
    end else if (accept && instr_op == mmi_pkg::OP_IDLE && monitor_mode) begin
      idle_q       <= 1'b1;
      ext_int_en_q <= 1'b1;
    end else if (state_q == mmi_pkg::ST_HALT && irq_on) begin
      idle_q       <= 1'b0;
      ext_int_en_q <= 1'b0;
    end
  end

  // ==========================================================
  // channel flags; a number out of range does nothing
  genvar ch;
  generate
    for (ch = 0; ch < mmi_pkg::CHAN_N; ch++) begin : g_chan
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          chan_flag_q[ch] <= 1'b0;
        end else begin
          chan_flag_q[ch] <= accept && monitor_mode &&
                             instr_op == mmi_pkg::OP_CHAN &&
                             instr_r == 8'(ch + 1);
        end
      end
    end
  endgenerate

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_pop_start;
    accept && instr_op == mmi_pkg::OP_POPCNT && pop_len != 16'h0;
  endsequence
  sequence s_pop_busy;
    mem_req_q && !instr_ready_q;
  endsequence

  a_pop_fetch: assert property (s_pop_start |=> s_pop_busy)
    else $error("field scan did not start a memory read");
  a_pop_clear: assert property (rf_we_q |-> rf_wdata_q[63:16] == 48'h0)
    else $error("count write left upper bits set");
  a_keypoint_nop: assert property (accept &&
    instr_op == mmi_pkg::OP_KEYPOINT |=> instr_done_q && instr_ready_q)
    else $error("keypoint did not finish in one cycle");
  a_bp_load: assert property (accept && instr_op == mmi_pkg::OP_BRKPT &&
    !exchange_to_monitor |=> bp_q == $past(reg_r_val))
    else $error("breakpoint register not loaded");
  a_bp_clear: assert property (exchange_to_monitor |=> bp_q == 64'h0)
    else $error("breakpoint not cleared on exchange");
  a_bp_after_done: assert property (bp_flag_q |-> $past(exec_done))
    else $error("breakpoint flag before completion");
  a_bp_excluded: assert property (ref_valid && ref_excl && !bp_pend_q &&
    !exec_done |=> !bp_pend_q)
    else $error("excluded reference matched");
  a_void_branch: assert property (accept && instr_op == mmi_pkg::OP_VOID
    |=> stack_void_q && branch_q &&
        branch_addr_q == $past(reg_t_val[AW-1:0]))
    else $error("void and branch wrong");
  a_fault_job: assert property (accept && instr_op == mmi_pkg::OP_FAULT &&
    !monitor_mode |=> $stable(ecc_bypass_q) && $stable(checkword_inv_q))
    else $error("fault test acted in job mode");
  a_trap_job: assert property (accept && priv_op && !monitor_mode
    |=> trap_q && trap_fcode_q == $past(instr_op) && !instr_done_q)
    else $error("monitor opcode not trapped");
  a_idle_hold: assert property (idle_q && !irq_on |=> idle_q &&
    ext_int_en_q)
    else $error("idle left without interrupt");
endmodule // mmi_instr_unit
`default_nettype wire

// [mmi_instr_unit_tb.sv]
// self-checking bench for the maintenance instruction unit
`timescale 1ns/1ps
`default_nettype none
module mmi_instr_unit_tb;
  // ==========================================================
  // design signals, named as the ports for .* hookup
  logic clk, rst_n, instr_valid, monitor_mode, instr_ready_q, instr_done_q;
  logic rf_we_q, mem_req_q, mem_ack, ref_valid, ref_scalar, ref_table;
  logic ref_io, exec_done, exchange_to_monitor, bp_flag_q, stack_void_q;
  logic branch_q, ecc_bypass_q, trap_q, ext_irq, ext_int_en_q, idle_q;
  logic [7:0] instr_op, instr_r, instr_t, rf_waddr_q, trap_fcode_q;
  logic [7:0] trap_entry_reg_q;
  logic [2:0] ref_slot;
  logic [6:0] checkword_inv_q;
  logic [11:0] chan_flag_q;
  logic [47:0] instr_paddr, mem_addr_q, ref_vaddr, ref_aaddr, exec_vaddr;
  logic [47:0] exec_aaddr, branch_addr_q, trap_paddr_q, p, st;
  logic [63:0] reg_r_val, reg_s_val, reg_t_val, rf_wdata_q, mem_rdata, w;
  logic [15:0] ln;
  int fails, checks, k, i, e;

  mmi_instr_unit i_mmi_instr_unit (.*);
  mmi_mem_model i_mmi_mem_model (.*);

  always #20 clk = ~clk; // 25 MHz

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, exp);
    end
  endtask

  // offer one instruction, return in its done or trap cycle
  task automatic issue(input logic [7:0] op, r, t, input logic [63:0] rv, tv);
    int n = 0;
    @(posedge clk);
    {instr_valid, instr_op, instr_r, instr_t} <= {1'b1, op, r, t};
    {reg_r_val, reg_s_val, reg_t_val} <= {rv, 64'hffff_0000_0000_0028, tv};
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    while (instr_done_q !== 1'b1 && trap_q !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 400) fails++;
  endtask

  // one reference, then its completion, then the flag cycle
  task automatic bp_try(input logic [2:0] s, input logic [47:0] va, aa, pv,
                        input logic [2:0] ex, input logic exp);
    @(posedge clk);
    {ref_valid, ref_slot, ref_vaddr, ref_aaddr} <= {1'b1, s, va, aa};
    {ref_scalar, ref_table, ref_io} <= ex;
    @(posedge clk);
    {ref_valid, exec_done, exec_vaddr, exec_aaddr} <= {2'b01, pv, pv};
    #1;
    chk(bp_flag_q, 1'b0);
    @(posedge clk);
    exec_done <= 1'b0;
    #1;
    chk(bp_flag_q, exp);
  endtask

  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // watchdog, well beyond the few hundred cycles needed
  initial begin
    #400000;
    fails++;
    give_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    {clk, rst_n, instr_valid, monitor_mode, ref_valid, ref_scalar} = '0;
    {ref_table, ref_io, exec_done, exchange_to_monitor, ext_irq} = '0;
    {instr_op, instr_r, instr_t, ref_slot, ref_vaddr, ref_aaddr} = '0;
    {exec_vaddr, exec_aaddr, reg_r_val, reg_s_val, reg_t_val} = '0;
    instr_paddr = 48'h0000_0abc_de40;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    monitor_mode <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(instr_ready_q, 1'b1);
    issue(8'h03, 8'h00, 8'h00, 64'h0, 64'h0);
    chk({instr_done_q, stack_void_q, rf_we_q, trap_q}, 4'h8);
    issue(8'h05, 8'h00, 8'h02, 64'h0, 64'hffff_1234_5678_9ab0);
    chk({stack_void_q, branch_q, branch_addr_q}, 50'h3_1234_5678_9ab0);
    issue(8'h06, 8'ha5, 8'h00, 64'h0, 64'h0);
    chk({ecc_bypass_q, checkword_inv_q}, 8'ha5);
    issue(8'h06, 8'h00, 8'h00, 64'h0, 64'h0);
    chk({ecc_bypass_q, checkword_inv_q}, 8'h00);
    for (k = 0; k < 14; k++) begin
      issue(8'h08, k[7:0], 8'h00, 64'h0, 64'h0);
      chk(chan_flag_q, (k >= 1 && k <= 12) ? 64'h1 << (k - 1) : 64'h0);
    end
    fork
      issue(8'h00, 8'h00, 8'h00, 64'h0, 64'h0);
      begin
        repeat (4) @(posedge clk);
        #1;
        chk({idle_q, ext_int_en_q, instr_done_q}, 3'h6);
        ext_irq <= 1'b1;
      end
    join
    chk(instr_done_q, 1'b1);
    ext_irq <= 1'b0;
    // field counts: aligned whole word, and a run over three words
    for (k = 0; k < 2; k++) begin
      ln = k ? 16'd100 : 16'd64;
      st = k ? 48'h1035 : 48'h2000;
      issue(8'h1f, 8'h01, 8'h07, {ln, st - 48'd40}, 64'h0);
      e = 0;
      for (i = 0; i < ln; i++) begin
        p = st + 48'(i);
        w = {p[37:6], ~p[37:6]};
        e += w[63 - p[5:0]];
      end
      chk({rf_we_q, rf_waddr_q, mem_req_q}, 10'h20e);
      chk(rf_wdata_q, 64'(e));
    end
    monitor_mode <= 1'b0;
    issue(8'h06, 8'hff, 8'h00, 64'h0, 64'h0);
    chk({ecc_bypass_q, checkword_inv_q, instr_done_q}, 9'h001);
    for (k = 0; k < 9; k += 8) begin
      issue(k[7:0], 8'h03, 8'h00, 64'h0, 64'h0);
      chk({trap_q, instr_done_q, trap_fcode_q, trap_entry_reg_q},
          {2'b10, k[7:0], 8'h03});
      chk(trap_paddr_q, instr_paddr);
    end
    // each operand usage bit alone, in job mode
    for (k = 0; k < 6; k++) begin
      issue(8'h04, 8'h02, 8'h00, (64'h1 << (48 + k)) | 64'h12000, 64'h0);
      bp_try(k[2:0], 48'h121ff, 48'h0, 48'h0, 3'h0, 1'b1);
      bp_try(3'((k + 1) % 6), 48'h12000, 48'h0, 48'h0, 3'h0, 1'b0);
    end
    issue(8'h04, 8'h02, 8'h00, 64'h0060_0000_0001_2000, 64'h0);
    bp_try(3'h5, 48'h12200, 48'h0, 48'h0, 3'h0, 1'b0);
    bp_try(3'h5, 48'h0, 48'h12000, 48'h0, 3'h0, 1'b0);
    bp_try(3'h5, 48'h12000, 48'h0, 48'h0, 3'h4, 1'b0);
    bp_try(3'h5, 48'h12000, 48'h0, 48'h0, 3'h2, 1'b0);
    bp_try(3'h5, 48'h12000, 48'h0, 48'h0, 3'h1, 1'b0);
    bp_try(3'h0, 48'h0, 48'h0, 48'h1201f, 3'h0, 1'b1);
    bp_try(3'h0, 48'h0, 48'h0, 48'h12020, 3'h0, 1'b0);
    monitor_mode <= 1'b1;
    bp_try(3'h5, 48'h0, 48'h12100, 48'h0, 3'h0, 1'b1);
    @(posedge clk);
    exchange_to_monitor <= 1'b1;
    @(posedge clk);
    exchange_to_monitor <= 1'b0;
    bp_try(3'h5, 48'h12000, 48'h12000, 48'h12000, 3'h0, 1'b0);
    give_verdict();
  end
endmodule // mmi_instr_unit_tb
`default_nettype wire

// [mmi_mem_model.sv]
// memory responder answering the unit's field scan reads
`timescale 1ns/1ps
`default_nettype none
module mmi_mem_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // read request from the unit
  input  wire logic        mem_req_q,
  input  wire logic [47:0] mem_addr_q,
  // answer
  output logic             mem_ack,
  output logic [63:0]      mem_rdata
);
  logic [1:0] wait_q; // cycles left before answering
  logic       slow_q; // alternates prompt and slow answers

  // ==========================================================
  // one word per request; stale data is inverted so that a
  // late sample by the unit cannot pass for a good word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {mem_ack, mem_rdata, wait_q, slow_q} <= '0;
    end else if (!mem_req_q || mem_ack) begin
      // released or just answered: wait for the next word
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_q <= slow_q ? 2'h3 : 2'h0;
      slow_q <= ~slow_q;
    end else if (wait_q == 2'h0) begin
      // word content tied to its address
      mem_ack <= 1'b1;
      mem_rdata <= {mem_addr_q[37:6], ~mem_addr_q[37:6]};
    end else begin
      wait_q <= wait_q - 2'h1;
    end
  end
endmodule // mmi_mem_model
`default_nettype wire

// [mmi_ones_count.sv]
// counts ones in a selected span of one memory word
`timescale 1ns/1ps
`default_nettype none
module mmi_ones_count #(
  parameter int W = 64
) (
  // word and span, bit 0 of the span is the word's msb
  input  wire logic [W-1:0] word,
  input  wire logic [5:0]   first,
  input  wire logic [6:0]   n,
  // result
  output logic [6:0]        ones
);
  logic [W-1:0] sel; // one per counted bit position

  // ==========================================================
  // span mask, numbered from the left as the field is scanned
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_sel
      localparam logic [6:0] POS = 7'(i);
      assign sel[W-1-i] = (POS >= {1'b0, first}) &&
                          (POS < ({1'b0, first} + n));
    end
  endgenerate

  // ==========================================================
  // adder tree left to the tool; one word per cycle is enough
  always_comb begin
    ones = 7'h00;
    for (int k = 0; k < W; k++) begin
      ones = ones + {6'h00, word[k] & sel[k]};
    end
  end
endmodule // mmi_ones_count
`default_nettype wire

// [mmi_pkg.sv]
// constants shared by the maintenance and monitor instruction unit
`default_nettype none
package mmi_pkg;
  // ==========================================================
  // opcodes handled here
  localparam logic [7:0] OP_IDLE     = 8'h00; // wait for interrupt
  localparam logic [7:0] OP_KEYPOINT = 8'h03; // one-cycle no-op
  localparam logic [7:0] OP_BRKPT    = 8'h04; // load breakpoint
  localparam logic [7:0] OP_VOID     = 8'h05; // void stack, branch
  localparam logic [7:0] OP_FAULT    = 8'h06; // memory fault test
  localparam logic [7:0] OP_CHAN     = 8'h08; // raise channel flag
  localparam logic [7:0] OP_POPCNT   = 8'h1f; // count ones in field

  // ==========================================================
  // widths and field positions (bit 0 is the lsb here)
  localparam int ADDR_W    = 48;  // bit address width
  localparam int WORD_W    = 64;  // register width
  localparam int LEN_LSB   = 48;  // field length sits in 63:48
  localparam int BP_USE_HI = 54;  // usage bit for program address
  localparam int BP_USE_LO = 48;  // usage bit for y order vector
  localparam int HALF_LSB  = 5;   // half-word granule, 32 bits
  localparam int SWORD_LSB = 9;   // sword granule, 512 bits
  localparam int WORD_LSB  = 6;   // memory word granule, 64 bits
  localparam int FT_BYPASS = 7;   // designator bit 8 in r field

  // ==========================================================
  // operand reference slots, index into the usage field
  localparam logic [2:0] REF_A = 3'h5; // a / random read
  localparam logic [2:0] REF_B = 3'h4; // b operand
  localparam logic [2:0] REF_C = 3'h3; // c / random write
  localparam logic [2:0] REF_Z = 3'h2; // z control vector
  localparam logic [2:0] REF_X = 3'h1; // x order vector
  localparam logic [2:0] REF_Y = 3'h0; // y order vector

  // ==========================================================
  // channel range, trap entry register, reset values
  localparam logic [7:0]  CHAN_MIN  = 8'h01;
  localparam logic [7:0]  CHAN_MAX  = 8'h0c;
  localparam int          CHAN_N    = 12;
  localparam logic [7:0]  TRAP_REG  = 8'h03;
  localparam logic [63:0] BP_RESET  = 64'h0;
  localparam logic [6:0]  INV_RESET = 7'h00;

  // control sequencer, gray along ready -> fetch -> halt
  typedef enum logic [1:0] {
    ST_READY = 2'b00,
    ST_FETCH = 2'b01,
    ST_HALT  = 2'b11
  } mmi_state_e;
endpackage : mmi_pkg
`default_nettype wire
